// *** core/rlsm_pkg.sv ***
package rlsm_pkg;

    // ------------------------------------------------------------
    // location indices; byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [5:0] IDX_LEVEL_ADJ   = 6'h20;
    localparam logic [5:0] IDX_STABILITY_ADJUSTER_ADJ    = 6'h21;
    localparam logic [5:0] IDX_USPD_ADJ    = 6'h22;
    localparam logic [5:0] IDX_EXC_ADJ     = 6'h23;
    localparam logic [5:0] IDX_OUT_LEVEL   = 6'h24;
    localparam logic [5:0] IDX_OUT_FREQ    = 6'h25;
    localparam logic [5:0] IDX_ALARMS      = 6'h26;
    localparam logic [5:0] IDX_ACT_CFG     = 6'h27;
    localparam logic [5:0] IDX_CMD_WORD    = 6'h28;
    localparam logic [5:0] IDX_EXT_INPUT   = 6'h29;
    localparam logic [5:0] IDX_NOM_SETPT   = 6'h2a;
    localparam logic [5:0] IDX_WORK_SETPT  = 6'h2b;
    localparam logic [5:0] IDX_MEAS_LEVEL  = 6'h2c;
    localparam logic [5:0] IDX_EXC_TEMP    = 6'h2d;
    localparam logic [5:0] IDX_REMOTE_REF  = 6'h31;
    localparam logic [5:0] IDX_PK_PK       = 6'h32;
    localparam logic [5:0] IDX_PHASE_THR   = 6'h33;
    localparam logic [5:0] IDX_ACQ_OFFSET  = 6'h34;
    localparam logic [5:0] IDX_PROP_GAIN   = 6'h35;
    localparam logic [5:0] IDX_INT_GAIN    = 6'h36;
    localparam logic [5:0] IDX_OVEREXC_THR = 6'h37;
    localparam logic [5:0] IDX_UNDEREXC    = 6'h38;

    // ------------------------------------------------------------
    // configuration word bit positions
    // ------------------------------------------------------------
    localparam int CFG_OFFSET_COMP = 2;
    localparam int CFG_JUMPER_EN   = 4;
    localparam int CFG_THREE_PHASE = 6;
    localparam int CFG_RAM_REMOTE  = 7;
    localparam int CFG_EXT_INPUT   = 12;
    localparam int CFG_SIXTY_HZ    = 14;

    // ------------------------------------------------------------
    // reset values and the default stored configuration
    // ------------------------------------------------------------
    localparam logic [15:0] RST_WORD     = 16'h0000;
    localparam logic [15:0] CFG_DEFAULT  = 16'h1f34;
    localparam logic [15:0] ACT_1P_50    = 16'h1f34;
    localparam logic [15:0] ACT_1P_60    = 16'h5f34;
    localparam logic [15:0] ACT_3P_50    = 16'h1f70;
    localparam logic [15:0] ACT_3P_60    = 16'h5f70;
    localparam logic [31:0] RD_UNMAPPED  = 32'h0000_0000;

endpackage

// *** core/rlsm_status_map.sv ***
`timescale 1ns/1ps

// Contract
// - output level in tenths of a volt, read-only at location 36.
// - output frequency in tenths of a hertz, read-only at location 37.
// - external potentiometer or analogue input value, read-only at 41.
// - working setpoint at 43, kept apart from nominal setpoint at 42.
// - exciter winding temperature estimate, read-only at location 45.
// - location 49 steers voltage only with external input off and bit 7 set.
// - offset value at 52 updates only during single-phase sensing.
// - location 53 holds proportional gain before its power-of-two scaling.
// - location 54 holds integral gain before its power-of-two scaling.
// - overexcitation trip threshold, read-only at location 55.
// - underexcitation observer, read-only at location 56.
// - active configuration at 39 is refreshed every cycle.
// - active bits 2, 6, 14 follow real operating state, not only storage.
// - active bit 6 reads one whenever three-phase sensing is connected.
// - active bit 14 reads one with 60 Hz jumper fitted and reading enabled.
// - default words: 7988, 24372, 8048, 24432 for the four cases.
// - bits 1, 4, 5, 7 report their stored functions; bit 2 only with single-phase sensing.
// - bits 8 to 12 report adjuster and input enables; bit 13 converter.
// - with bit 7 set, location 49 is a volatile software reference.
// - with bit 7 clear, location 49 tracks stored level; writes ignored.
module rlsm_status_map
(
    input  wire logic        mclk,
    input  wire logic        reset,
    // avalon-mm slave, byte addressed
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [3:0]  avs_byteenable,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // live values from the regulator core
    input  wire logic [15:0] level_adjuster_pos,
    input  wire logic [15:0] stability_adjuster_pos,
    input  wire logic [15:0] underspeed_adjuster_pos,
    input  wire logic [15:0] excitation_adjuster_pos,
    input  wire logic [15:0] output_level,
    input  wire logic [15:0] output_freq,
    input  wire logic [15:0] alarm_flags,
    input  wire logic [15:0] external_input,
    input  wire logic [15:0] nominal_setpoint,
    input  wire logic [15:0] working_setpoint,
    input  wire logic [15:0] measured_level,
    input  wire logic [15:0] exciter_temp,
    input  wire logic [15:0] peak_to_peak,
    input  wire logic [15:0] phase_switch_thr,
    input  wire logic [15:0] offset_sample,
    input  wire logic [15:0] proportional_gain_base,
    input  wire logic [15:0] integral_gain_base,
    input  wire logic [15:0] overexc_threshold,
    input  wire logic [15:0] underexc_observer,
    // stored settings and operating state
    input  wire logic [15:0] stored_config,
    input  wire logic [15:0] stored_remote_level,
    input  wire logic        three_phase_connected,
    input  wire logic        jumper_60hz_fitted,
    // results towards the regulator core
    output logic      [15:0] remote_level_ref,
    output logic             remote_ref_active,
    output logic      [15:0] active_config,
    output logic      [15:0] acquisition_offset,
    output logic      [15:0] command_word,
    output logic             command_strobe
);

    // ------------------------------------------------------------
    // bus handshake
    // ------------------------------------------------------------
    logic        ack_ff;
    logic [31:0] rdata_ff;
    logic [15:0] ref_ff;
    logic        ref_act_ff;
    logic [15:0] act_cfg_ff;
    logic [15:0] offset_ff;
    logic [15:0] cmd_ff;
    logic        cmd_stb_ff;
    logic        req;
    logic        wr_done;
    logic [5:0]  idx;
    logic        aligned;
    logic [15:0] wmask;
    logic [15:0] nxt_act_cfg;
    logic [31:0] nxt_rdata;
    logic        wr_ref_hit;
    logic        wr_cmd_hit;

    // word index of a byte address; low two bits must be zero
    function automatic logic [5:0] word_index(input logic [7:0] addr);
        word_index = addr[7:2];
    endfunction

    // a write lands only at its accepting edge and on an aligned address;
    // any other write is dropped without an error response
    function automatic logic write_hit
    (
        input logic       done,
        input logic       align,
        input logic [5:0] at,
        input logic [5:0] target
    );
        write_hit = done & align & (at == target);
    endfunction

    assign req     = avs_read | avs_write;
    assign idx     = word_index(avs_address);
    assign aligned = (avs_address[1:0] == 2'b00);
    assign wr_done = avs_write & ack_ff;
    assign wmask   = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

    // only these two locations keep what the host writes
    assign wr_ref_hit = write_hit(wr_done, aligned, idx, rlsm_pkg::IDX_REMOTE_REF);
    assign wr_cmd_hit = write_hit(wr_done, aligned, idx, rlsm_pkg::IDX_CMD_WORD);

    // one wait state per access; readdata is ready when wait drops
    assign avs_waitrequest = req & ~ack_ff;

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
            ack_ff <= 1'b0;
        else
            ack_ff <= req & ~ack_ff;   // drops after the accepting edge
    end

    // ------------------------------------------------------------
    // active configuration word
    // ------------------------------------------------------------
    // rebuilt from live state every cycle so a read never sees stale bits
    always_comb
    begin
        nxt_act_cfg = stored_config;
        // offset compensation only acts with single-phase sensing
        nxt_act_cfg[rlsm_pkg::CFG_OFFSET_COMP] =
            stored_config[rlsm_pkg::CFG_OFFSET_COMP] & ~three_phase_connected;
        nxt_act_cfg[rlsm_pkg::CFG_THREE_PHASE] =
            stored_config[rlsm_pkg::CFG_THREE_PHASE] | three_phase_connected;
        nxt_act_cfg[rlsm_pkg::CFG_SIXTY_HZ] =
            stored_config[rlsm_pkg::CFG_SIXTY_HZ]
            | (stored_config[rlsm_pkg::CFG_JUMPER_EN] & jumper_60hz_fitted);
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
            act_cfg_ff <= rlsm_pkg::RST_WORD;
        else
            act_cfg_ff <= nxt_act_cfg;
    end

    // ------------------------------------------------------------
    // acquisition offset, frozen in three-phase sensing
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
            offset_ff <= rlsm_pkg::RST_WORD;
        else if (!three_phase_connected)
            offset_ff <= offset_sample;
    end

    // ------------------------------------------------------------
    // remote level reference
    // ------------------------------------------------------------
    // volatile only while bit 7 is set; otherwise mirrors the stored level
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
            ref_ff <= rlsm_pkg::RST_WORD;
        else if (!stored_config[rlsm_pkg::CFG_RAM_REMOTE])
            ref_ff <= stored_remote_level;
        else if (wr_ref_hit)
            ref_ff <= (ref_ff & ~wmask) | (avs_writedata[15:0] & wmask);
    end

    // steering only when the analogue input is disabled
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
            ref_act_ff <= 1'b0;
        else
            ref_act_ff <= stored_config[rlsm_pkg::CFG_RAM_REMOTE]
                          & ~stored_config[rlsm_pkg::CFG_EXT_INPUT];
    end

    // ------------------------------------------------------------
    // reserved command word, stored and passed on untouched
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            cmd_ff     <= rlsm_pkg::RST_WORD;
            cmd_stb_ff <= 1'b0;
        end
        else
        begin
            cmd_stb_ff <= wr_cmd_hit;
            if (wr_cmd_hit)
                cmd_ff <= (cmd_ff & ~wmask) | (avs_writedata[15:0] & wmask);
        end
    end

    // ------------------------------------------------------------
    // read multiplexer
    // ------------------------------------------------------------
    // writes to every other index fall through: no storage exists there
    always_comb
    begin
        nxt_rdata = rlsm_pkg::RD_UNMAPPED;
        if (aligned)
        begin
            case (idx)
                rlsm_pkg::IDX_LEVEL_ADJ:   nxt_rdata[15:0] = level_adjuster_pos;
                rlsm_pkg::IDX_STABILITY_ADJUSTER_ADJ:    nxt_rdata[15:0] = stability_adjuster_pos;
                rlsm_pkg::IDX_USPD_ADJ:    nxt_rdata[15:0] = underspeed_adjuster_pos;
                rlsm_pkg::IDX_EXC_ADJ:     nxt_rdata[15:0] = excitation_adjuster_pos;
                rlsm_pkg::IDX_OUT_LEVEL:   nxt_rdata[15:0] = output_level;
                rlsm_pkg::IDX_OUT_FREQ:    nxt_rdata[15:0] = output_freq;
                rlsm_pkg::IDX_ALARMS:      nxt_rdata[15:0] = alarm_flags;
                rlsm_pkg::IDX_ACT_CFG:     nxt_rdata[15:0] = act_cfg_ff;
                rlsm_pkg::IDX_EXT_INPUT:   nxt_rdata[15:0] = external_input;
                rlsm_pkg::IDX_NOM_SETPT:   nxt_rdata[15:0] = nominal_setpoint;
                rlsm_pkg::IDX_WORK_SETPT:  nxt_rdata[15:0] = working_setpoint;
                rlsm_pkg::IDX_MEAS_LEVEL:  nxt_rdata[15:0] = measured_level;
                rlsm_pkg::IDX_EXC_TEMP:    nxt_rdata[15:0] = exciter_temp;
                rlsm_pkg::IDX_REMOTE_REF:  nxt_rdata[15:0] = ref_ff;
                rlsm_pkg::IDX_PK_PK:       nxt_rdata[15:0] = peak_to_peak;
                rlsm_pkg::IDX_PHASE_THR:   nxt_rdata[15:0] = phase_switch_thr;
                rlsm_pkg::IDX_ACQ_OFFSET:  nxt_rdata[15:0] = offset_ff;
                rlsm_pkg::IDX_PROP_GAIN:   nxt_rdata[15:0] = proportional_gain_base;
                rlsm_pkg::IDX_INT_GAIN:    nxt_rdata[15:0] = integral_gain_base;
                rlsm_pkg::IDX_OVEREXC_THR: nxt_rdata[15:0] = overexc_threshold;
                rlsm_pkg::IDX_UNDEREXC:    nxt_rdata[15:0] = underexc_observer;
                default:                   nxt_rdata = rlsm_pkg::RD_UNMAPPED;
            endcase
        end
    end

    // captured on the first edge of a read, stands until the next read
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
            rdata_ff <= rlsm_pkg::RD_UNMAPPED;
        else if (avs_read && !ack_ff)
            rdata_ff <= nxt_rdata;
    end

    assign avs_readdata       = rdata_ff;
    assign remote_level_ref   = ref_ff;
    assign remote_ref_active  = ref_act_ff;
    assign active_config      = act_cfg_ff;
    assign acquisition_offset = offset_ff;
    assign command_word       = cmd_ff;
    assign command_strobe     = cmd_stb_ff;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_wait_one_cycle: assert property (@(posedge mclk) disable iff (reset)
        (req && !ack_ff) ##1 req |-> !avs_waitrequest)
        else $error("waitrequest not released after one cycle");

    a_read_level: assert property (@(posedge mclk) disable iff (reset)
        (avs_read && !ack_ff && avs_address == {rlsm_pkg::IDX_OUT_LEVEL, 2'b00})
        |=> avs_readdata[15:0] == $past(output_level) && avs_readdata[31:16] == 16'h0000)
        else $error("level read returned wrong value");

    // the !reset guards skip the releasing edge, at which the
    // registers still take their reset values
    a_three_phase_bit: assert property (@(posedge mclk) disable iff (reset)
        !reset && three_phase_connected |=> active_config[rlsm_pkg::CFG_THREE_PHASE])
        else $error("bit 6 clear with three-phase sensing");

    a_sixty_hz_bit: assert property (@(posedge mclk) disable iff (reset)
        !reset && stored_config[rlsm_pkg::CFG_JUMPER_EN] && jumper_60hz_fitted
        |=> active_config[rlsm_pkg::CFG_SIXTY_HZ])
        else $error("bit 14 clear with 60 Hz jumper read");

    a_default_words: assert property (@(posedge mclk) disable iff (reset)
        !reset && stored_config == rlsm_pkg::CFG_DEFAULT
        |=> active_config == ($past(three_phase_connected)
            ? ($past(jumper_60hz_fitted) ? rlsm_pkg::ACT_3P_60 : rlsm_pkg::ACT_3P_50)
            : ($past(jumper_60hz_fitted) ? rlsm_pkg::ACT_1P_60 : rlsm_pkg::ACT_1P_50)))
        else $error("active configuration differs from default table");

    a_offset_frozen: assert property (@(posedge mclk) disable iff (reset)
        three_phase_connected |=> $stable(acquisition_offset))
        else $error("offset moved during three-phase sensing");

    a_ref_tracks: assert property (@(posedge mclk) disable iff (reset)
        !reset && !stored_config[rlsm_pkg::CFG_RAM_REMOTE]
        |=> remote_level_ref == $past(stored_remote_level))
        else $error("reference does not track stored level");

    a_ref_write: assert property (@(posedge mclk) disable iff (reset)
        wr_done && stored_config[rlsm_pkg::CFG_RAM_REMOTE] && avs_byteenable[1:0] == 2'b11
        && avs_address == {rlsm_pkg::IDX_REMOTE_REF, 2'b00}
        |=> remote_level_ref == $past(avs_writedata[15:0]))
        else $error("reference write lost");

    a_ro_write_ignored: assert property (@(posedge mclk) disable iff (reset)
        wr_done && stored_config[rlsm_pkg::CFG_RAM_REMOTE]
        && avs_address != {rlsm_pkg::IDX_REMOTE_REF, 2'b00}
        |=> $stable(remote_level_ref))
        else $error("write elsewhere changed the reference");

    a_steer_active: assert property (@(posedge mclk) disable iff (reset)
        stored_config[rlsm_pkg::CFG_EXT_INPUT] |=> !remote_ref_active)
        else $error("reference steers with analogue input on");

    a_freq_read: assert property (@(posedge mclk) disable iff (reset)
        avs_read && !ack_ff && avs_address == {rlsm_pkg::IDX_OUT_FREQ, 2'b00}
        |=> avs_readdata == {16'h0000, $past(output_freq)})
        else $error("frequency read returned wrong value");

    a_unmapped_zero: assert property (@(posedge mclk) disable iff (reset)
        avs_read && !ack_ff
        && idx > rlsm_pkg::IDX_EXC_TEMP && idx < rlsm_pkg::IDX_REMOTE_REF
        |=> avs_readdata == rlsm_pkg::RD_UNMAPPED)
        else $error("unmapped read returned data");

    a_ref_readback: assert property (@(posedge mclk) disable iff (reset)
        avs_read && !ack_ff && avs_address == {rlsm_pkg::IDX_REMOTE_REF, 2'b00}
        |=> avs_readdata == {16'h0000, $past(remote_level_ref)})
        else $error("reference read returned wrong value");

    // bits 2, 6 and 14 follow live state; the rest mirror storage
    a_comp_bit: assert property (@(posedge mclk) disable iff (reset)
        !reset && three_phase_connected
        |=> !active_config[rlsm_pkg::CFG_OFFSET_COMP])
        else $error("compensation shown with three-phase sensing");

    a_copied_bits: assert property (@(posedge mclk) disable iff (reset)
        !reset
        |=> (active_config & 16'hbfbb) == ($past(stored_config) & 16'hbfbb))
        else $error("stored configuration bit lost");

    a_offset_tracks: assert property (@(posedge mclk) disable iff (reset)
        !reset && !three_phase_connected
        |=> acquisition_offset == $past(offset_sample))
        else $error("offset not loaded in single-phase sensing");

    a_steer_on: assert property (@(posedge mclk) disable iff (reset)
        !reset && stored_config[rlsm_pkg::CFG_RAM_REMOTE]
        && !stored_config[rlsm_pkg::CFG_EXT_INPUT] |=> remote_ref_active)
        else $error("reference not steering with analogue input off");

    a_ref_locked: assert property (@(posedge mclk) disable iff (reset)
        stored_config[rlsm_pkg::CFG_RAM_REMOTE] && !wr_ref_hit
        |=> $stable(remote_level_ref))
        else $error("volatile reference moved without a write");

    a_cmd_quiet: assert property (@(posedge mclk) disable iff (reset)
        !wr_cmd_hit |=> !command_strobe)
        else $error("command strobe without a command write");

    // cover points for the main scenarios
    c_read_cfg: cover property (@(posedge mclk) disable iff (reset)
        avs_read && ack_ff && avs_address == {rlsm_pkg::IDX_ACT_CFG, 2'b00});

    c_write_ref: cover property (@(posedge mclk) disable iff (reset)
        wr_done && remote_ref_active && avs_address == {rlsm_pkg::IDX_REMOTE_REF, 2'b00});

    c_three_phase_60: cover property (@(posedge mclk) disable iff (reset)
        active_config == rlsm_pkg::ACT_3P_60);

    c_offset_held: cover property (@(posedge mclk) disable iff (reset)
        three_phase_connected && offset_sample != acquisition_offset);

    c_ro_write_locked: cover property (@(posedge mclk) disable iff (reset)
        wr_done && remote_ref_active && avs_address == {rlsm_pkg::IDX_OUT_LEVEL, 2'b00});

endmodule // rlsm_status_map

// *** verification/rlsm_bench.sv ***
`timescale 1ns/1ps

module regulator_live_status_map_bench;

    // ----------------------------------------------------------------
    // stimulus and observation signals
    // ----------------------------------------------------------------
    logic        mclk;
    logic        reset;
    logic [7:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [15:0] live [0:18];
    logic [15:0] stored_config;
    logic [15:0] stored_remote_level;
    logic        three_phase_connected;
    logic        jumper_60hz_fitted;
    logic [15:0] remote_level_ref;
    logic        remote_ref_active;
    logic [15:0] active_config;
    logic [15:0] acquisition_offset;
    logic [15:0] command_word;
    logic        command_strobe;
    int          n_errors;
    int          total_checks;
    logic [31:0] rd;

    // location of each live input, in port order
    logic [5:0] idx_tab [0:18] = '{rlsm_pkg::IDX_LEVEL_ADJ, rlsm_pkg::IDX_STABILITY_ADJUSTER_ADJ,
        rlsm_pkg::IDX_USPD_ADJ, rlsm_pkg::IDX_EXC_ADJ, rlsm_pkg::IDX_OUT_LEVEL,
        rlsm_pkg::IDX_OUT_FREQ, rlsm_pkg::IDX_ALARMS, rlsm_pkg::IDX_EXT_INPUT,
        rlsm_pkg::IDX_NOM_SETPT, rlsm_pkg::IDX_WORK_SETPT, rlsm_pkg::IDX_MEAS_LEVEL,
        rlsm_pkg::IDX_EXC_TEMP, rlsm_pkg::IDX_PK_PK, rlsm_pkg::IDX_PHASE_THR,
        rlsm_pkg::IDX_ACQ_OFFSET, rlsm_pkg::IDX_PROP_GAIN, rlsm_pkg::IDX_INT_GAIN,
        rlsm_pkg::IDX_OVEREXC_THR, rlsm_pkg::IDX_UNDEREXC};

    // stored word, three-phase, jumper, expected active word
    logic [15:0] cfg_tab [0:6] = '{16'h1f34, 16'h1f34, 16'h1f34, 16'h1f34,
                                   16'h20a2, 16'h0000, 16'h4004};
    logic [1:0]  st_tab  [0:6] = '{2'b00, 2'b01, 2'b10, 2'b11, 2'b01, 2'b10, 2'b10};
    logic [15:0] act_tab [0:6] = '{rlsm_pkg::ACT_1P_50, rlsm_pkg::ACT_1P_60,
                                   rlsm_pkg::ACT_3P_50, rlsm_pkg::ACT_3P_60,
                                   16'h20a2, 16'h0040, 16'h4040};

    rlsm_status_map dut
    (
        .mclk                    (mclk),
        .reset                   (reset),
        .avs_address             (avs_address),
        .avs_read                (avs_read),
        .avs_write               (avs_write),
        .avs_byteenable          (avs_byteenable),
        .avs_writedata           (avs_writedata),
        .avs_readdata            (avs_readdata),
        .avs_waitrequest         (avs_waitrequest),
        .level_adjuster_pos      (live[0]),
        .stability_adjuster_pos  (live[1]),
        .underspeed_adjuster_pos (live[2]),
        .excitation_adjuster_pos (live[3]),
        .output_level            (live[4]),
        .output_freq             (live[5]),
        .alarm_flags             (live[6]),
        .external_input          (live[7]),
        .nominal_setpoint        (live[8]),
        .working_setpoint        (live[9]),
        .measured_level          (live[10]),
        .exciter_temp            (live[11]),
        .peak_to_peak            (live[12]),
        .phase_switch_thr        (live[13]),
        .offset_sample           (live[14]),
        .proportional_gain_base  (live[15]),
        .integral_gain_base      (live[16]),
        .overexc_threshold       (live[17]),
        .underexc_observer       (live[18]),
        .stored_config           (stored_config),
        .stored_remote_level     (stored_remote_level),
        .three_phase_connected   (three_phase_connected),
        .jumper_60hz_fitted      (jumper_60hz_fitted),
        .remote_level_ref        (remote_level_ref),
        .remote_ref_active       (remote_ref_active),
        .active_config           (active_config),
        .acquisition_offset      (acquisition_offset),
        .command_word            (command_word),
        .command_strobe          (command_strobe)
    );

    // ----------------------------------------------------------------
    // clock, reset and watchdog
    // ----------------------------------------------------------------
    initial
    begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // whole run needs well under 5000 cycles
    initial
    begin
        #(20 * 5000);
        n_errors++;
        complete_run();
    end

    // ----------------------------------------------------------------
    // access tasks and comparisons
    // ----------------------------------------------------------------
    // one bus cycle; held until waitrequest is seen low at an edge
    task automatic bus(input logic wr, input logic [5:0] idx, input logic [15:0] wd);
        int n;
        n = 0;
        @(posedge mclk);
        avs_address   <= {idx, 2'b00};
        avs_read      <= ~wr;
        avs_write     <= wr;
        avs_writedata <= {16'h0000, wd};
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50)
            n_errors++;
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // read a location and compare the returned word
    task automatic read_check(input logic [5:0] idx, input logic [15:0] exp);
        bus(1'b0, idx, 16'h0000);
        check_word(rd, {16'h0000, exp});
    endtask

    task automatic complete_run;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // test sequence
    // ----------------------------------------------------------------
    initial
    begin
        n_errors = 0;
        total_checks = 0;
        reset = 1'b1;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'b0011;
        for (int i = 0; i < 19; i++)
            live[i] = 16'h0a00 + 16'(i * 16'h0111);
        stored_config = rlsm_pkg::CFG_DEFAULT;
        stored_remote_level = 16'h2345;
        three_phase_connected = 1'b0;
        jumper_60hz_fitted = 1'b0;
        repeat (12) @(posedge mclk);
        reset <= 1'b0;
        // every live value at its own location
        for (int i = 0; i < 19; i++)
            read_check(idx_tab[i], live[i]);
        // writes to read-only places leave the live value
        bus(1'b1, rlsm_pkg::IDX_OUT_LEVEL, 16'h7e7e);
        read_check(rlsm_pkg::IDX_OUT_LEVEL, live[4]);
        read_check(6'h2e, 16'h0000);
        // active word follows stored bits and operating state
        for (int i = 0; i < 7; i++)
        begin
            stored_config <= cfg_tab[i];
            three_phase_connected <= st_tab[i][1];
            jumper_60hz_fitted <= st_tab[i][0];
            read_check(rlsm_pkg::IDX_ACT_CFG, act_tab[i]);
            check_word({16'h0000, active_config}, {16'h0000, act_tab[i]});
        end
        // offset held in three-phase, tracks in single-phase
        live[14] <= 16'h0bbb;
        read_check(rlsm_pkg::IDX_ACQ_OFFSET, 16'h0a00 + 16'(14 * 16'h0111));
        three_phase_connected <= 1'b0;
        read_check(rlsm_pkg::IDX_ACQ_OFFSET, 16'h0bbb);
        check_word({16'h0000, acquisition_offset}, 32'h0000_0bbb);
        // remote reference: tracks storage while bit 7 clear
        stored_config <= rlsm_pkg::CFG_DEFAULT;
        bus(1'b1, rlsm_pkg::IDX_REMOTE_REF, 16'h7777);
        read_check(rlsm_pkg::IDX_REMOTE_REF, 16'h2345);
        check_word({31'h0, remote_ref_active}, 32'h0000_0000);
        // bit 7 set with external input on: writable, not steering
        stored_config <= rlsm_pkg::CFG_DEFAULT | 16'h0080;
        bus(1'b1, rlsm_pkg::IDX_REMOTE_REF, 16'h7777);
        read_check(rlsm_pkg::IDX_REMOTE_REF, 16'h7777);
        check_word({31'h0, remote_ref_active}, 32'h0000_0000);
        // external input off: the volatile reference steers
        stored_config <= (rlsm_pkg::CFG_DEFAULT | 16'h0080) & ~16'h1000;
        bus(1'b1, rlsm_pkg::IDX_REMOTE_REF, 16'h1357);
        read_check(rlsm_pkg::IDX_REMOTE_REF, 16'h1357);
        check_word({31'h0, remote_ref_active}, 32'h0000_0001);
        check_word({16'h0000, remote_level_ref}, 32'h0000_1357);
        // read-only write while the reference is live, then a one-lane write
        bus(1'b1, rlsm_pkg::IDX_OUT_LEVEL, 16'h0f0f);
        read_check(rlsm_pkg::IDX_REMOTE_REF, 16'h1357);
        avs_byteenable <= 4'b0001;
        bus(1'b1, rlsm_pkg::IDX_REMOTE_REF, 16'hffaa);
        avs_byteenable <= 4'b0011;
        read_check(rlsm_pkg::IDX_REMOTE_REF, 16'h13aa);
        check_word({16'h0000, command_word}, 32'h0000_0000);
        check_word({31'h0, command_strobe}, 32'h0000_0000);
        complete_run();
    end

endmodule // regulator_live_status_map_bench
